// ### apwmt_map.vh
// Constants for the PWM timer control and capture block
`ifndef APWMT_MAP_VH
`define APWMT_MAP_VH
`define APWMT_CNT_W        16
`define APWMT_CNT_ZERO     16'h0000
`define APWMT_CNT_ONE      16'h0001
`define APWMT_TOP_RST      16'h00FF
`define APWMT_CMP_RST      8'h80
`define APWMT_DT_RST       8'h04
`define APWMT_DT_ZERO      8'h00
`define APWMT_DT_ONE       8'h01
`define APWMT_DIT_ZERO     4'h0
`define APWMT_DIT_ONE      4'h1
`define APWMT_MODE_ONE     2'h0
`define APWMT_MODE_TWO     2'h1
`define APWMT_MODE_FOUR    2'h2
`define APWMT_MODE_DUAL    2'h3
`define APWMT_DSEL_ONA     2'h0
`define APWMT_DSEL_ONB     2'h1
`define APWMT_DSEL_DTB     2'h2
`define APWMT_DSEL_DTAB    2'h3
`define APWMT_SYNC_LAT     2'h2
`define APWMT_SYNC_ZERO    2'h0
`define APWMT_SYNC_ONE     2'h1
`define APWMT_RAMP_LAST    2'h3
`define APWMT_RAMP_ZERO    2'h0
`define APWMT_RAMP_ONE     2'h1
`endif

// ### apwmt_capture.v
// One capture unit holding a counter snapshot in the core clock domain
`timescale 1ns/1ps
`default_nettype none
`include "apwmt_map.vh"
module apwmt_capture (
   input  wire                     core_clk,
   input  wire                     rst,
   input  wire                     trig,
   input  wire [`APWMT_CNT_W-1:0]  cnt,
   output reg  [`APWMT_CNT_W-1:0]  value_r,
   output reg                      done_r
);
   always @(posedge core_clk) begin
      if (rst) begin
         value_r <= `APWMT_CNT_ZERO;
         done_r  <= 1'b0;
      end else begin
         done_r <= trig;
         if (trig) begin
            value_r <= cnt;
         end
      end
   end
endmodule // apwmt_capture
`default_nettype wire

// ### apwmt_top.v
// PWM timer enable sequencing, command strobes, dither and capture
`timescale 1ns/1ps
`default_nettype none
`include "apwmt_map.vh"
// Contract
// - Enable clear stops timer after sync
// - End-of-cycle disable stops at cycle end
// - Control fields writable only while disabled
// - Enable changes only while ready flag
// - Commands forwarded when enabled, sync idle
// - Command strobes clear when done
// - Zero-cycle dither lengthens state, shortens next
// - One-ramp DTB dither: DTB+1, ONB-1
// - Four-ramp returns to zero four times
// - Dual-ramp counts up then down
// - Two capture units copy counter
// - Capture sets trigger flag A/B
// - Interrupt while flag set and enabled
// - Software capture valid at command ready
module apwmt_top (
   input  wire                     core_clk,
   input  wire                     rst,
   input  wire                     ctrl_a_we,
   input  wire                     ctrl_a_enable,
   input  wire [1:0]               ctrl_a_mode,
   input  wire                     cmd_we,
   input  wire                     cmd_disable_eoc,
   input  wire                     cmd_capture_a,
   input  wire                     cmd_capture_b,
   input  wire                     event_control_reg_a_action,
   input  wire                     event_control_reg_b_action,
   input  wire                     event_a,
   input  wire                     event_b,
   input  wire [1:0]               dither_target_select,
   input  wire [3:0]               dither_step,
   input  wire                     intflag_clr_a,
   input  wire                     intflag_clr_b,
   input  wire                     int_en_a,
   input  wire                     int_en_b,
   input  wire                     cap_byte_sel,
   output reg                      enable_ready_flag_r,
   output reg                      command_ready_flag_r,
   output reg                      enabled_r,
   output reg  [1:0]               mode_r,
   output reg  [2:0]               command_strobe_reg_r,
   output reg                      trigger_a_flag_r,
   output reg                      trigger_b_flag_r,
   output reg                      irq_r,
   output reg  [7:0]               cap_a_byte_r,
   output reg  [7:0]               cap_b_byte_r,
   output reg                      pwm_a_r,
   output reg                      pwm_b_r,
   output reg  [`APWMT_CNT_W-1:0]  cycle_len_r
);
   localparam ST_ONA = 4'b0001;
   localparam ST_DTB = 4'b0010;
   localparam ST_ONB = 4'b0100;
   localparam ST_DTA = 4'b1000;

   reg  [1:0]              en_sync_r;
   reg  [1:0]              cmd_sync_r;
   reg                     en_req_r;
   reg  [`APWMT_CNT_W-1:0] cnt_r;
   reg                     down_r;
   reg  [1:0]              ramp_r;
   reg  [3:0]              state_r;
   reg  [7:0]              st_cnt_r;
   reg  [3:0]              dit_acc_r;
   reg                     dit_ext_r;
   reg                     eoc_pend_r;
   reg  [2:0]              cmd_lat_r;
   reg  [3:0]              state_nxt;
   reg  [4:0]              dit_sum;
   wire [`APWMT_CNT_W-1:0] cap_a_val;
   wire [`APWMT_CNT_W-1:0] cap_b_val;
   wire                    cap_a_done;
   wire                    cap_b_done;
   wire                    cyc_end;
   wire                    trig_a;
   wire                    trig_b;
   wire                    sync_idle;

   assign sync_idle = (en_sync_r == `APWMT_SYNC_ZERO) && (cmd_sync_r == `APWMT_SYNC_ZERO);
   // Cycle ends at top in one-ramp, at one on way down in dual, after four ramps
   assign cyc_end = (mode_r == `APWMT_MODE_DUAL) ? (down_r && cnt_r == `APWMT_CNT_ONE) :
                    (mode_r == `APWMT_MODE_FOUR) ? (cnt_r == `APWMT_TOP_RST &&
                                                    ramp_r == `APWMT_RAMP_LAST) :
                    (cnt_r == `APWMT_TOP_RST);
   assign trig_a = (event_control_reg_a_action && event_a) || (cmd_lat_r[1] && cmd_sync_r == `APWMT_SYNC_ONE);
   assign trig_b = (event_control_reg_b_action && event_b) || (cmd_lat_r[2] && cmd_sync_r == `APWMT_SYNC_ONE);

   // Enable and control writes; two-cycle latency models the core-domain crossing
   always @(posedge core_clk) begin
      if (rst) begin
         en_req_r            <= 1'b0;
         mode_r              <= `APWMT_MODE_ONE;
         en_sync_r           <= `APWMT_SYNC_ZERO;
         enable_ready_flag_r <= 1'b1;
         enabled_r           <= 1'b0;
      end else begin
         if (ctrl_a_we && enable_ready_flag_r) begin
            en_req_r            <= ctrl_a_enable;
            en_sync_r           <= `APWMT_SYNC_LAT;
            enable_ready_flag_r <= 1'b0;
            if (!enabled_r && !en_req_r) begin
               mode_r <= ctrl_a_mode;
            end
         end else if (en_sync_r != `APWMT_SYNC_ZERO) begin
            en_sync_r <= en_sync_r - `APWMT_SYNC_ONE;
            if (en_sync_r == `APWMT_SYNC_ONE) begin
               enabled_r           <= en_req_r;
               enable_ready_flag_r <= 1'b1;
            end
         end else if (enabled_r && eoc_pend_r && cyc_end) begin
            enabled_r <= 1'b0;
            en_req_r  <= 1'b0;
         end
      end
   end

   // Command strobes; a write while busy is dropped, software must poll ready
   always @(posedge core_clk) begin
      if (rst) begin
         command_strobe_reg_r <= 3'h0;
         cmd_lat_r            <= 3'h0;
         cmd_sync_r           <= `APWMT_SYNC_ZERO;
         command_ready_flag_r <= 1'b1;
         eoc_pend_r           <= 1'b0;
      end else begin
         if (cmd_we && enabled_r && sync_idle && command_ready_flag_r) begin
            command_strobe_reg_r <= {cmd_capture_b, cmd_capture_a, cmd_disable_eoc};
            cmd_lat_r            <= {cmd_capture_b, cmd_capture_a, cmd_disable_eoc};
            cmd_sync_r           <= `APWMT_SYNC_LAT;
            command_ready_flag_r <= 1'b0;
         end else if (cmd_sync_r != `APWMT_SYNC_ZERO) begin
            cmd_sync_r <= cmd_sync_r - `APWMT_SYNC_ONE;
            if (cmd_sync_r == `APWMT_SYNC_ONE) begin
               command_strobe_reg_r <= 3'h0;
               cmd_lat_r            <= 3'h0;
               command_ready_flag_r <= 1'b1;
               eoc_pend_r           <= eoc_pend_r | cmd_lat_r[0];
            end
         end
         if (!enabled_r) begin
            eoc_pend_r <= 1'b0;
         end
      end
   end

   // Counter per ramp mode
   always @(posedge core_clk) begin
      if (rst || !enabled_r) begin
         cnt_r  <= `APWMT_CNT_ZERO;
         down_r <= 1'b0;
         ramp_r <= `APWMT_RAMP_ZERO;
      end else if (mode_r == `APWMT_MODE_DUAL) begin
         if (!down_r && cnt_r == `APWMT_TOP_RST) begin
            down_r <= 1'b1;
            cnt_r  <= cnt_r - `APWMT_CNT_ONE;
         end else if (down_r && cnt_r == `APWMT_CNT_ZERO) begin
            down_r <= 1'b0;
            cnt_r  <= cnt_r + `APWMT_CNT_ONE;
         end else begin
            cnt_r <= down_r ? cnt_r - `APWMT_CNT_ONE : cnt_r + `APWMT_CNT_ONE;
         end
      end else if (cnt_r == `APWMT_TOP_RST) begin
         cnt_r  <= `APWMT_CNT_ZERO;
         ramp_r <= (mode_r == `APWMT_MODE_FOUR) ? ramp_r + `APWMT_RAMP_ONE : `APWMT_RAMP_ZERO;
      end else begin
         cnt_r <= cnt_r + `APWMT_CNT_ONE;
      end
   end

   // Output state sequence; dither extension borrowed from the following state
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_ONA:  state_nxt = ST_DTB;
         ST_DTB:  state_nxt = ST_ONB;
         ST_ONB:  state_nxt = ST_DTA;
         ST_DTA:  state_nxt = ST_ONA;
         default: state_nxt = ST_ONA;
      endcase
   end

   always @* begin
      dit_sum = {1'b0, dit_acc_r} + {1'b0, dither_step};
   end

   always @(posedge core_clk) begin
      if (rst || !enabled_r) begin
         state_r   <= ST_DTA;
         st_cnt_r  <= `APWMT_DT_RST;
         dit_acc_r <= `APWMT_DIT_ZERO;
         dit_ext_r <= 1'b0;
         pwm_a_r   <= 1'b0;
         pwm_b_r   <= 1'b0;
      end else begin
         if (st_cnt_r == `APWMT_DT_ZERO) begin
            state_r <= state_nxt;
            if (state_r == ST_DTA) begin
               dit_acc_r <= dit_sum[3:0];
            end
            // DTB+1 then ONB-1
            // Dead-times A and B together stretch both dead states on one overflow
            if ((state_nxt == ST_DTB && (dither_target_select == `APWMT_DSEL_DTB ||
                                         dither_target_select == `APWMT_DSEL_DTAB)) ||
                (state_nxt == ST_DTA && dither_target_select == `APWMT_DSEL_DTAB)) begin
               st_cnt_r  <= dit_sum[4] ? `APWMT_DT_RST : `APWMT_DT_RST - `APWMT_DT_ONE;
               dit_ext_r <= dit_sum[4];
            end else if (state_nxt == ST_ONB || state_nxt == ST_ONA) begin
               st_cnt_r  <= dit_ext_r ? `APWMT_CMP_RST - `APWMT_DT_ONE - `APWMT_DT_ONE :
                                        `APWMT_CMP_RST - `APWMT_DT_ONE;
               dit_ext_r <= 1'b0;
            end else begin
               st_cnt_r <= `APWMT_DT_RST - `APWMT_DT_ONE;
            end
         end else begin
            st_cnt_r <= st_cnt_r - `APWMT_DT_ONE;
         end
         pwm_a_r <= (state_r == ST_ONA);
         pwm_b_r <= (state_r == ST_ONB);
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         cycle_len_r <= `APWMT_TOP_RST + `APWMT_CNT_ONE;
      end else if (dither_target_select == `APWMT_DSEL_DTB ||
                   dither_target_select == `APWMT_DSEL_DTAB) begin
         cycle_len_r <= `APWMT_TOP_RST + `APWMT_CNT_ONE;
      end else begin
         cycle_len_r <= `APWMT_TOP_RST + `APWMT_CNT_ONE + {15'h0000, dit_sum[4]};
      end
   end

   apwmt_capture u_cap_a (
      .core_clk (core_clk),
      .rst      (rst),
      .trig     (trig_a),
      .cnt      (cnt_r),
      .value_r  (cap_a_val),
      .done_r   (cap_a_done)
   );

   apwmt_capture u_cap_b (
      .core_clk (core_clk),
      .rst      (rst),
      .trig     (trig_b),
      .cnt      (cnt_r),
      .value_r  (cap_b_val),
      .done_r   (cap_b_done)
   );

   // capture sets flag, set wins over clear
   always @(posedge core_clk) begin
      if (rst) begin
         trigger_a_flag_r <= 1'b0;
         trigger_b_flag_r <= 1'b0;
         irq_r            <= 1'b0;
         cap_a_byte_r     <= 8'h00;
         cap_b_byte_r     <= 8'h00;
      end else begin
         trigger_a_flag_r <= cap_a_done | (trigger_a_flag_r & ~intflag_clr_a);
         trigger_b_flag_r <= cap_b_done | (trigger_b_flag_r & ~intflag_clr_b);
         irq_r <= ((cap_a_done | (trigger_a_flag_r & ~intflag_clr_a)) & int_en_a) |
                  ((cap_b_done | (trigger_b_flag_r & ~intflag_clr_b)) & int_en_b);
         // Byte view of held captures, low when select is zero
         cap_a_byte_r <= cap_byte_sel ? cap_a_val[15:8] : cap_a_val[7:0];
         cap_b_byte_r <= cap_byte_sel ? cap_b_val[15:8] : cap_b_val[7:0];
      end
   end
endmodule // apwmt_top
`default_nettype wire

// ### apwmt_dummy_end.v
// Intentionally empty companion file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### apwmt_top_asserts.sv
// Concurrent checks on the PWM timer control and capture ports
`timescale 1ns/1ps
`default_nettype none
module apwmt_chk (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic       ctrl_a_we,
   input wire logic       ctrl_a_enable,
   input wire logic       cmd_we,
   input wire logic       cmd_disable_eoc,
   input wire logic       cmd_capture_a,
   input wire logic       cmd_capture_b,
   input wire logic       event_control_reg_a_action,
   input wire logic       event_a,
   input wire logic       int_en_a,
   input wire logic       enable_ready_flag_r,
   input wire logic       command_ready_flag_r,
   input wire logic       enabled_r,
   input wire logic [1:0] mode_r,
   input wire logic [2:0] command_strobe_reg_r,
   input wire logic       trigger_a_flag_r,
   input wire logic       trigger_b_flag_r,
   input wire logic       irq_r
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Command taken only when enabled and both handshakes idle
   wire cmd_ok;
   assign cmd_ok = cmd_we && enabled_r && command_ready_flag_r && enable_ready_flag_r;
   // ready drops on a taken write
   a_ready_drop: assert property (ctrl_a_we && enable_ready_flag_r |=> !enable_ready_flag_r)
      else $error("enable ready did not drop");
   a_enable_lat: assert property (ctrl_a_we && enable_ready_flag_r |-> ##3
      (enabled_r == $past(ctrl_a_enable, 3) && enable_ready_flag_r))
      else $error("enable not applied three cycles after write");
   a_mode_frozen: assert property (enabled_r && $past(enabled_r) && $past(enabled_r, 4)
      && $past(enabled_r, 2) && $past(enabled_r, 3) |-> $stable(mode_r))
      else $error("mode changed while enabled");
   a_cmd_show: assert property (cmd_ok && (cmd_capture_a || cmd_capture_b) |=>
      command_strobe_reg_r == {$past(cmd_capture_b), $past(cmd_capture_a), $past(cmd_disable_eoc)}
      && !command_ready_flag_r)
      else $error("command strobe not shown");
   a_cmd_clear: assert property (cmd_ok && (cmd_capture_a || cmd_capture_b) && !cmd_disable_eoc
      |-> ##3 (command_strobe_reg_r == 3'h0 && command_ready_flag_r))
      else $error("command strobe did not clear");
   a_cap_flag: assert property (cmd_ok && cmd_capture_a |-> ##4 trigger_a_flag_r)
      else $error("software capture flag missing");
   a_evt_flag: assert property (event_a && event_control_reg_a_action && enabled_r |-> ##2 trigger_a_flag_r)
      else $error("event capture flag missing");
   a_flag_source: assert property ($rose(trigger_a_flag_r) |->
      ($past(event_a, 2) && $past(event_control_reg_a_action, 2)) || $past(command_strobe_reg_r[1], 2))
      else $error("capture flag without trigger");
   a_irq_source: assert property (irq_r |-> trigger_a_flag_r || trigger_b_flag_r)
      else $error("interrupt without flag");
   // request held with flag and enable
   a_irq_level: assert property (trigger_a_flag_r && $past(int_en_a) |-> irq_r)
      else $error("interrupt missing");
   c_cmd: cover property (cmd_ok && cmd_capture_a);
   c_evt: cover property (event_a && event_control_reg_a_action && enabled_r);
   c_irq: cover property ($rose(irq_r));
endmodule // apwmt_chk
`default_nettype wire

// ### apwmt_evsrc.sv
// Event source: one go pulse feeding both capture inputs
`timescale 1ns/1ps
`default_nettype none
module apwmt_evsrc (
   input  wire logic       core_clk,
   input  wire logic       go,
   input  wire logic [7:0] gap,
   output var  logic       event_a,
   output var  logic       event_b
);
   logic [8:0] cnt_r = 9'h000;
   initial event_a = 1'b0;
   initial event_b = 1'b0;
   // rising edge on input A, rising edge gap cycles later on B
   always @(posedge core_clk) begin
      event_a <= go;
      event_b <= (cnt_r == 9'h001);
      if (go) begin
         cnt_r <= {1'b0, gap};
      end else if (cnt_r != 9'h000) begin
         cnt_r <= cnt_r - 9'h001;
      end
   end
endmodule // apwmt_evsrc
`default_nettype wire

// ### apwmt_top_test.sv
// Self-checking testbench for the PWM timer control and capture block
`timescale 1ns/1ps
`default_nettype none
`include "apwmt_map.vh"
module apwmt_top_test;
   logic core_clk = 1'b0, rst = 1'b1, ctrl_a_we = 1'b0, ctrl_a_enable = 1'b0, cmd_we = 1'b0;
   logic cmd_disable_eoc = 1'b0, cmd_capture_a = 1'b0, cmd_capture_b = 1'b0, go = 1'b0;
   logic event_control_reg_a_action = 1'b0, event_control_reg_b_action = 1'b0, intflag_clr_a = 1'b0;
   logic intflag_clr_b = 1'b0, int_en_a = 1'b0, int_en_b = 1'b0, cap_byte_sel = 1'b0;
   logic [1:0]  ctrl_a_mode = 2'h0, dither_target_select = 2'h0;
   logic [3:0]  dither_step = 4'h0;
   logic [7:0]  gap = 8'h0a;
   logic [15:0] va, vb, v1;
   wire logic   event_a, event_b, enable_ready_flag_r, command_ready_flag_r, enabled_r;
   wire logic   trigger_a_flag_r, trigger_b_flag_r, irq_r, pwm_a_r, pwm_b_r;
   wire logic [1:0]  mode_r;
   wire logic [2:0]  command_strobe_reg_r;
   wire logic [7:0]  cap_a_byte_r, cap_b_byte_r;
   wire logic [15:0] cycle_len_r;
   int fail_count = 0, checks = 0, cyc = 0, n;
   // Free-running 20 MHz clock
   always #25 core_clk = ~core_clk;
   apwmt_top dut (.*);
   apwmt_evsrc u_ev (.core_clk(core_clk), .go(go), .gap(gap), .event_a(event_a), .event_b(event_b));
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Poll both handshakes, bounded so a stuck flag shows up as mismatches
   task automatic wait_rdy;
      for (int i = 0; i < 20 && !(enable_ready_flag_r && command_ready_flag_r); i++) tick(1);
   endtask
   task automatic pulse_ctrl(input logic en, input logic [1:0] md);
      ctrl_a_enable = en;
      ctrl_a_mode = md;
      ctrl_a_we = 1'b1;
      tick(1);
      ctrl_a_we = 1'b0;
   endtask
   // wait for ready before every control write
   task automatic wr(input logic en, input logic [1:0] md);
      wait_rdy;
      pulse_ctrl(en, md);
      tick(1);
      wait_rdy;
   endtask
   task automatic cmd(input logic e, input logic a, input logic b);
      wait_rdy;
      {cmd_disable_eoc, cmd_capture_a, cmd_capture_b, cmd_we} = {e, a, b, 1'b1};
      tick(1);
      {cmd_disable_eoc, cmd_capture_a, cmd_capture_b, cmd_we} = 4'h0;
      tick(1);
   endtask
   // low byte first, then high byte
   task automatic rd_cap(output logic [15:0] a, output logic [15:0] b);
      cap_byte_sel = 1'b0;
      tick(2);
      {a[7:0], b[7:0]} = {cap_a_byte_r, cap_b_byte_r};
      cap_byte_sel = 1'b1;
      tick(2);
      {a[15:8], b[15:8]} = {cap_a_byte_r, cap_b_byte_r};
   endtask
   task automatic clr(input logic a, input logic b);
      {intflag_clr_a, intflag_clr_b} = {a, b};
      tick(1);
      {intflag_clr_a, intflag_clr_b} = 2'h0;
      tick(1);
   endtask
   // dead time B gap and on time B width
   task automatic meas(output logic [15:0] g, output logic [15:0] w);
      g = 16'h0000;
      w = 16'h0000;
      for (int i = 0; i < 300 && pwm_a_r !== 1'b1; i++) tick(1);
      for (int i = 0; i < 300 && pwm_a_r === 1'b1; i++) tick(1);
      for (int i = 0; i < 300 && pwm_b_r !== 1'b1; i++) begin
         tick(1);
         g++;
      end
      for (int i = 0; i < 300 && pwm_b_r === 1'b1; i++) begin
         tick(1);
         w++;
      end
   endtask
   task automatic test_done;
      if (fail_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Hang guard, far above the expected few thousand cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         test_done;
      end
   end
   // Main sequence
   initial begin
      tick(6);
      rst = 1'b0;
      check({enable_ready_flag_r, command_ready_flag_r, enabled_r, command_strobe_reg_r, irq_r}, 16'h0060);
      check(cycle_len_r, 16'h0100);
      cmd(1'b0, 1'b1, 1'b0);
      tick(4);
      check({command_strobe_reg_r, trigger_a_flag_r}, 16'h0000);
      wait_rdy;
      pulse_ctrl(1'b1, `APWMT_MODE_ONE);
      tick(1);
      check(enable_ready_flag_r, 16'h0000);
      pulse_ctrl(1'b0, `APWMT_MODE_ONE);
      wait_rdy;
      tick(3);
      check(enabled_r, 16'h0001);
      wr(1'b1, `APWMT_MODE_DUAL);
      check(mode_r, `APWMT_MODE_ONE);
      {event_control_reg_a_action, event_control_reg_b_action, int_en_a} = 3'h7;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(16);
      rd_cap(va, vb);
      check((vb - va) & 16'h00ff, 16'h000a);
      check({trigger_a_flag_r, trigger_b_flag_r, irq_r}, 16'h0007);
      clr(1'b1, 1'b0);
      check({trigger_a_flag_r, irq_r}, 16'h0000);
      clr(1'b0, 1'b1);
      event_control_reg_a_action = 1'b0;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(16);
      check({trigger_a_flag_r, trigger_b_flag_r}, 16'h0001);
      clr(1'b0, 1'b1);
      cmd(1'b0, 1'b1, 1'b1);
      wait_rdy;
      tick(2);
      check({trigger_a_flag_r, trigger_b_flag_r, irq_r}, 16'h0007);
      rd_cap(va, vb);
      tick(40);
      rd_cap(v1, vb);
      check(v1, va);
      clr(1'b1, 1'b1);
      dither_step = 4'hf;
      // Dead-time targets must keep the cycle length, on-time targets stretch it
      for (int s = 0; s < 4; s++) begin
         dither_target_select = s[1:0];
         n = 0;
         repeat (600) begin
            tick(1);
            if (cycle_len_r !== 16'h0100) n++;
         end
         check({15'h0000, n != 0}, {15'h0000, s < 2});
      end
      wr(1'b0, `APWMT_MODE_ONE);
      check(enabled_r, 16'h0000);
      // Fresh accumulator overflows on the first cycle with a full step
      dither_target_select = `APWMT_DSEL_DTB;
      wr(1'b1, `APWMT_MODE_ONE);
      meas(va, vb);
      check(va, 16'h0005);
      check(vb, 16'h007f);
      dither_target_select = `APWMT_DSEL_ONA;
      meas(va, vb);
      check(va, 16'h0004);
      check(vb, 16'h0080);
      wr(1'b0, `APWMT_MODE_ONE);
      wr(1'b0, `APWMT_MODE_DUAL);
      check(mode_r, `APWMT_MODE_DUAL);
      wr(1'b1, `APWMT_MODE_DUAL);
      cmd(1'b1, 1'b0, 1'b0);
      tick(20);
      check(enabled_r, 16'h0001);
      for (n = 0; n < 1100 && enabled_r === 1'b1; n++) tick(1);
      check(enabled_r, 16'h0000);
      // Four ramps make the cycle four counter periods long
      wr(1'b1, `APWMT_MODE_FOUR);
      cmd(1'b1, 1'b0, 1'b0);
      tick(600);
      check(enabled_r, 16'h0001);
      for (n = 0; n < 1100 && enabled_r === 1'b1; n++) tick(1);
      check(enabled_r, 16'h0000);
      test_done;
   end
endmodule // apwmt_top_test
bind apwmt_top apwmt_chk u_chk (.*);
`default_nettype wire
